// ### rtl/servo_fault_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SERVO_FAULT_CONSTS_SVH
`define SERVO_FAULT_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL        6'h00
`define OFS_POSITION    6'h04
`define OFS_COMMANDED   6'h08
`define OFS_SPEED       6'h0c
`define OFS_FAULT       6'h10
`define OFS_FAULT_EXIT  6'h14
`define OFS_STATUS      6'h18
`define OFS_TRIGGER     6'h1c
`define OFS_CYCLE       6'h20
`define OFS_SOFT_POS    6'h24
`define OFS_SOFT_NEG    6'h28
`define OFS_FOLLOW      6'h2c
`define OFS_SCALE       6'h30

// ****************************************
// Control bits
// ****************************************
`define CTL_DRIVE_EN    0
`define CTL_HARD_EN     1
`define CTL_SOFT_EN     2
`define CTL_GEAR_ON     3
`define CTL_HANDLER     4
`define CTL_QUALIFY     5
`define CTL_RUN         6
`define CYC_HOME        0
`define CYC_REG         1

// ****************************************
// Fault codes and limits
// ****************************************
`define FLT_NONE        8'h00
`define FLT_HARD_POS    8'h80
`define FLT_HARD_NEG    8'h81
`define FLT_SOFT_POS    8'h82
`define FLT_SOFT_NEG    8'h83
`define FLT_FOLLOW      8'h85
`define FLT_NO_DRIVE    8'h87
`define FLT_BACKLOG     8'h89
`define BACKLOG_MAX     32'h0000_7fff
`define FOLLOW_RESET    32'h0000_7fff
`define SCALE_RESET     32'h0000_0100
`define SCALE_SHIFT     8

// ****************************************
// Timing
// ****************************************
`define SAMPLE_US       1000
`define CLOCK_MHZ       10

`endif

// ### rtl/servo_fault_pkg.sv
// Types shared by the servo fault and trigger unit
package servo_fault_pkg;

    typedef enum logic [1:0] {RUN_IDLE, RUN_MAIN, RUN_FAULT} run_state_t;
    typedef enum logic [1:0] {CY_IDLE, CY_HOME, CY_REG, CY_INDEX} cycle_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [6:0]  ctrl;
        logic signed [31:0] position;
        logic signed [31:0] commanded;
        logic signed [31:0] pos_at_sample;
        logic signed [31:0] speed;
        logic [31:0] sample_cnt;
        logic [7:0]  fault;
        run_state_t  run;
        cycle_t      cycle;
        logic        trig_pol;
        logic        reg_en;
        logic        armed;
        logic        ev_meta;
        logic        ev_sync;
        logic        ev_prev;
        logic        enc_a;
        logic        enc_b;
        logic        home_pulse;
        logic        index_pulse;
        logic signed [31:0] soft_pos;
        logic signed [31:0] soft_neg;
        logic [31:0] follow;
        logic [31:0] scale;
    } unit_state_t;

endpackage

// ### rtl/servo_fault_trigger_unit.sv
// Encoder position and speed, fault latch, and first event trigger logic
// ****************************************
// ****************************************
`timescale 1ns/1ps
`include "servo_fault_consts.svh"

module servo_fault_trigger_unit
    import servo_fault_pkg::*;
#(
    parameter int SAMPLE_CYCLES = (`SAMPLE_US * `CLOCK_MHZ)
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Avalon-MM slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Encoder, limit switches, trigger sensor
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    input wire logic enc_index_i,
    input wire logic pos_limit_i,
    input wire logic neg_limit_i,
    input wire logic event_i,
    // Sequencer and gearing engine
    input wire logic [31:0] gear_backlog_i,
    input wire logic [7:0] cmd_fault_i,
    input wire logic move_req_i,
    input wire logic move_done_i,
    // Status outputs
    output logic fault_led_o,
    output logic drive_enable_o,
    output logic gearing_on_o,
    output logic program_run_o,
    output logic int_block_o,
    output logic home_trigger_o,
    output logic index_start_o,
    output logic event_rise_o,
    output logic event_fall_o
);

    unit_state_t s_ff;
    unit_state_t nxt_s;

    logic access;
    logic wr_en;
    logic rd_en;
    logic [63:0] scaled;
    logic signed [31:0] pos_err;
    logic [31:0] abs_err;
    logic ev_rise;
    logic ev_fall;
    logic trig_edge;
    logic [7:0] new_fault;
    logic limit_fault;
    logic step_up;
    logic step_dn;
    logic [31:0] wd;

    // ****************************************
    // Bus handshake
    // ****************************************
    // One wait state: read data is captured first, then presented
    assign access = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = access & ~s_ff.ack;
    assign wr_en = avs_write_i & s_ff.ack;
    assign rd_en = avs_read_i & s_ff.ack;
    assign avs_readdata_o = s_ff.rdata;
    assign wd = avs_writedata_i;

    assign scaled = 64'(signed'(s_ff.position) * signed'({1'b0, s_ff.scale}));

    assign ev_rise = s_ff.ev_sync & ~s_ff.ev_prev;
    assign ev_fall = ~s_ff.ev_sync & s_ff.ev_prev;
    assign trig_edge = s_ff.trig_pol ? ev_rise : ev_fall;

    assign pos_err = s_ff.commanded - s_ff.position;
    assign abs_err = pos_err[31] ? 32'(-pos_err) : 32'(pos_err);

    // Quadrature decode, four counts per line
    assign step_up = (enc_a_i ^ s_ff.enc_a ^ enc_b_i ^ s_ff.enc_b) &
                     ((enc_a_i ^ s_ff.enc_b) == 1'b1);
    assign step_dn = (enc_a_i ^ s_ff.enc_a ^ enc_b_i ^ s_ff.enc_b) &
                     ((enc_a_i ^ s_ff.enc_b) == 1'b0);

    // ****************************************
    // Fault sources in priority order
    // ****************************************
    always_comb begin
        new_fault = `FLT_NONE;
        limit_fault = 1'b0;
        if (s_ff.ctrl[`CTL_GEAR_ON] && s_ff.ctrl[`CTL_HARD_EN] &&
            pos_limit_i) begin
            new_fault = `FLT_HARD_POS;
            limit_fault = 1'b1;
        end else if (s_ff.ctrl[`CTL_GEAR_ON] && s_ff.ctrl[`CTL_HARD_EN] &&
                     neg_limit_i) begin
            new_fault = `FLT_HARD_NEG;
            limit_fault = 1'b1;
        end else if (s_ff.ctrl[`CTL_GEAR_ON] && s_ff.ctrl[`CTL_SOFT_EN] &&
                     s_ff.position > s_ff.soft_pos) begin
            new_fault = `FLT_SOFT_POS;
            limit_fault = 1'b1;
        end else if (s_ff.ctrl[`CTL_GEAR_ON] && s_ff.ctrl[`CTL_SOFT_EN] &&
                     s_ff.position < s_ff.soft_neg) begin
            new_fault = `FLT_SOFT_NEG;
            limit_fault = 1'b1;
        end else if (s_ff.ctrl[`CTL_GEAR_ON] &&
                     gear_backlog_i > `BACKLOG_MAX) begin
            new_fault = `FLT_BACKLOG;
            limit_fault = 1'b1;
        end else if (s_ff.ctrl[`CTL_DRIVE_EN] && s_ff.follow != 32'h0 &&
                     abs_err > s_ff.follow) begin
            new_fault = `FLT_FOLLOW;
        end else if (move_req_i && !s_ff.ctrl[`CTL_DRIVE_EN]) begin
            new_fault = `FLT_NO_DRIVE;
        end else if (cmd_fault_i != 8'h0) begin
            new_fault = cmd_fault_i;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_s = s_ff;
        nxt_s.ack = access & ~s_ff.ack;
        nxt_s.home_pulse = 1'b0;
        nxt_s.index_pulse = 1'b0;
        nxt_s.ev_meta = event_i;
        nxt_s.ev_sync = s_ff.ev_meta;
        nxt_s.ev_prev = s_ff.ev_sync;
        nxt_s.enc_a = enc_a_i;
        nxt_s.enc_b = enc_b_i;

        if (step_up) begin
            nxt_s.position = s_ff.position + 32'sd1;
        end else if (step_dn) begin
            nxt_s.position = s_ff.position - 32'sd1;
        end

        // signed speed, one count per sample is the LSB
        if (s_ff.sample_cnt == 32'(SAMPLE_CYCLES - 1)) begin
            nxt_s.sample_cnt = 32'h0;
            nxt_s.speed = s_ff.position - s_ff.pos_at_sample;
            nxt_s.pos_at_sample = s_ff.position;
        end else begin
            nxt_s.sample_cnt = s_ff.sample_cnt + 32'h1;
        end

        // Capture read data during the wait state
        if (avs_read_i && !s_ff.ack) begin
            unique case (avs_address_i)
                `OFS_CTRL: nxt_s.rdata = {25'h0, s_ff.ctrl};
                `OFS_POSITION: nxt_s.rdata = scaled[`SCALE_SHIFT +: 32];
                `OFS_COMMANDED: nxt_s.rdata = s_ff.commanded;
                `OFS_SPEED: nxt_s.rdata = s_ff.speed;
                `OFS_FAULT: nxt_s.rdata = {24'h0, s_ff.fault};
                // synchronized event level readable as input 1
                `OFS_STATUS: nxt_s.rdata = {22'h0, s_ff.cycle, s_ff.run,
                                            s_ff.ev_sync, s_ff.armed,
                                            s_ff.reg_en, s_ff.trig_pol,
                                            (s_ff.run == RUN_FAULT),
                                            (s_ff.fault != 8'h0)};
                `OFS_TRIGGER: nxt_s.rdata = {30'h0, s_ff.reg_en,
                                             s_ff.trig_pol};
                `OFS_SOFT_POS: nxt_s.rdata = s_ff.soft_pos;
                `OFS_SOFT_NEG: nxt_s.rdata = s_ff.soft_neg;
                `OFS_FOLLOW: nxt_s.rdata = s_ff.follow;
                `OFS_SCALE: nxt_s.rdata = s_ff.scale;
                default: nxt_s.rdata = 32'h0;
            endcase
        end

        // ****************************************
        // Register writes
        // ****************************************
        if (wr_en) begin
            unique case (avs_address_i)
                `OFS_CTRL: begin
                    nxt_s.ctrl = wd[6:0];
                    if (wd[`CTL_RUN] && s_ff.run == RUN_IDLE) begin
                        nxt_s.run = RUN_MAIN;
                    end
                    if (!wd[`CTL_RUN]) begin
                        nxt_s.run = RUN_IDLE;
                    end
                end
                // commanded write also loads actual position
                `OFS_COMMANDED: begin
                    nxt_s.commanded = wd;
                    nxt_s.position = wd;
                end
                `OFS_TRIGGER: begin
                    // polarity for both home and registration; home trigger stays enabled
                    if (wd[31]) begin
                        nxt_s.trig_pol = 1'b0;
                        nxt_s.reg_en = 1'b1;
                    end else if (wd != 32'h0) begin
                        nxt_s.trig_pol = 1'b1;
                        nxt_s.reg_en = 1'b1;
                    // disable refused once a registration cycle has begun
                    end else if (s_ff.cycle != CY_REG &&
                                 s_ff.cycle != CY_INDEX) begin
                        nxt_s.reg_en = 1'b0;
                    end
                end
                `OFS_CYCLE: begin
                    if (s_ff.cycle == CY_IDLE && s_ff.ctrl[`CTL_DRIVE_EN]) begin
                        if (wd[`CYC_HOME]) begin
                            nxt_s.cycle = CY_HOME;
                        end else if (wd[`CYC_REG]) begin
                            nxt_s.cycle = CY_REG;
                        end
                        nxt_s.armed = 1'b0;
                    end
                end
                `OFS_SOFT_POS: nxt_s.soft_pos = wd;
                `OFS_SOFT_NEG: nxt_s.soft_neg = wd;
                `OFS_FOLLOW: nxt_s.follow = wd;
                `OFS_SCALE: nxt_s.scale = wd;
                default: begin
                end
            endcase
        end

        // ****************************************
        // Home and registration triggers
        // ****************************************
        unique case (s_ff.cycle)
            CY_IDLE: begin
            end
            CY_HOME, CY_REG: begin
                if (trig_edge && s_ff.ctrl[`CTL_QUALIFY]) begin
                    nxt_s.armed = 1'b1;
                end
                if ((s_ff.ctrl[`CTL_QUALIFY] && s_ff.armed && enc_index_i) ||
                    (!s_ff.ctrl[`CTL_QUALIFY] && trig_edge)) begin
                    nxt_s.armed = 1'b0;
                    if (s_ff.cycle == CY_HOME) begin
                        nxt_s.home_pulse = 1'b1;
                        nxt_s.cycle = CY_IDLE;
                    end else if (s_ff.reg_en) begin
                        nxt_s.index_pulse = 1'b1;
                        nxt_s.cycle = CY_INDEX;
                    end
                end
            end
            CY_INDEX: begin
                if (move_done_i) begin
                    nxt_s.cycle = CY_IDLE;
                end
            end
        endcase

        // ****************************************
        // Fault latch and program flow
        // ****************************************
        // fault read or branch back clears
        if ((rd_en && avs_address_i == `OFS_FAULT) ||
            (wr_en && avs_address_i == `OFS_FAULT_EXIT)) begin
            nxt_s.fault = `FLT_NONE;
        end
        if (wr_en && avs_address_i == `OFS_FAULT_EXIT &&
            s_ff.run == RUN_FAULT) begin
            nxt_s.run = RUN_MAIN;
        end
        // only first fault latches; a fault in the clear cycle wins
        if (new_fault != `FLT_NONE &&
            (s_ff.fault == `FLT_NONE || nxt_s.fault == `FLT_NONE)) begin
            nxt_s.fault = new_fault;
            if (limit_fault) begin
                nxt_s.ctrl[`CTL_GEAR_ON] = 1'b0;
            end
            // Follow error also drops the drive
            if (new_fault == `FLT_FOLLOW) begin
                nxt_s.ctrl[`CTL_DRIVE_EN] = 1'b0;
            end
            if (s_ff.run != RUN_IDLE) begin
                nxt_s.run = s_ff.ctrl[`CTL_HANDLER] ? RUN_FAULT : RUN_IDLE;
            end
            nxt_s.cycle = CY_IDLE;
            nxt_s.armed = 1'b0;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s_ff <= '{ack: 1'b0, rdata: 32'h0, ctrl: 7'h0,
                      position: 32'sh0, commanded: 32'sh0,
                      pos_at_sample: 32'sh0, speed: 32'sh0,
                      sample_cnt: 32'h0, fault: `FLT_NONE,
                      run: RUN_IDLE, cycle: CY_IDLE, trig_pol: 1'b1,
                      reg_en: 1'b1, armed: 1'b0, ev_meta: 1'b0,
                      ev_sync: 1'b0, ev_prev: 1'b0, enc_a: 1'b0,
                      enc_b: 1'b0, home_pulse: 1'b0, index_pulse: 1'b0,
                      soft_pos: 32'sh7fff_ffff, soft_neg: 32'sh8000_0000,
                      follow: `FOLLOW_RESET, scale: `SCALE_RESET};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // indicator follows fault number
    assign fault_led_o = (s_ff.fault != `FLT_NONE);
    assign drive_enable_o = s_ff.ctrl[`CTL_DRIVE_EN];
    assign gearing_on_o = s_ff.ctrl[`CTL_GEAR_ON];
    assign program_run_o = (s_ff.run != RUN_IDLE);
    assign int_block_o = (s_ff.run == RUN_FAULT);
    assign home_trigger_o = s_ff.home_pulse;
    assign index_start_o = s_ff.index_pulse;
    assign event_rise_o = ev_rise;
    assign event_fall_o = ev_fall;

endmodule

// ### sim/sensor_model.sv
// Behavioural encoder, limit switch and trigger sensor model
`timescale 1ns/1ps
module sensor_model (
    // Clock and stimulus controls
    input wire logic mclk_i,
    input wire logic spin_i, dir_i, ev_i, plim_i, nlim_i,
    // Sensor lines toward the unit
    output logic enc_a_o, enc_b_o, enc_index_o,
    output logic pos_limit_o, neg_limit_o, event_o,
    // Quadrature steps issued so far, signed by direction
    output int steps_o
);
    logic [1:0] ph = 2'h0;
    logic tog = 1'b0;
    int cnt = 0;
    // Gray sequence: only one line changes per count
    assign enc_a_o = ph[1];
    assign enc_b_o = ph[1] ^ ph[0];
    assign enc_index_o = (ph == 2'h0);
    assign pos_limit_o = plim_i;
    assign neg_limit_o = nlim_i;
    assign event_o = ev_i;
    assign steps_o = cnt;
    // One step every second clock keeps the rate exact per sample
    always @(posedge mclk_i) begin
        tog <= !tog;
        if (spin_i && tog) begin
            ph <= dir_i ? ph + 2'h1 : ph - 2'h1;
            cnt <= cnt + (dir_i ? 1 : -1);
        end
    end
endmodule

// ### sim/servo_unit_chk.sv
// Assertion checker bound to the servo fault and trigger unit
`timescale 1ns/1ps
`include "servo_fault_consts.svh"
module servo_unit_chk (
    // Clock, reset and bus
    input logic mclk_i, reset_i, avs_read_i, avs_write_i,
    input logic [5:0] avs_address_i,
    input logic avs_waitrequest_o,
    // Sensor and sequencer inputs
    input logic pos_limit_i, neg_limit_i, event_i, move_req_i,
    input logic enc_index_i,
    input logic [31:0] gear_backlog_i,
    input logic [7:0] cmd_fault_i,
    // Status outputs
    input logic fault_led_o, drive_enable_o, gearing_on_o,
    input logic program_run_o, int_block_o, home_trigger_o,
    input logic index_start_o, event_rise_o, event_fall_o
);
    logic rq, clr;
    assign rq = avs_read_i | avs_write_i;
    assign clr = rq && !avs_waitrequest_o &&
        (avs_read_i ? avs_address_i == `OFS_FAULT
                    : avs_address_i == `OFS_FAULT_EXIT);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // ****************************************
    // Handshake and reset
    // ****************************************
    a_wait_first: assert property ($rose(rq) |-> avs_waitrequest_o)
        else $error("no wait state on new request");
    a_wait_once: assert property (rq && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("more than one wait state");
    a_reset_quiet: assert property ($past(reset_i)
        |-> !fault_led_o && !gearing_on_o && !program_run_o && !int_block_o)
        else $error("outputs active after reset");
    // ****************************************
    // Fault latch
    // ****************************************
    a_led_hold: assert property (fault_led_o && !clr |=> fault_led_o)
        else $error("fault dropped without clear");
    a_clear_fault: assert property (clr && cmd_fault_i == 8'h00
        && !move_req_i && !gearing_on_o && !drive_enable_o
        |=> !fault_led_o) else $error("fault not cleared");
    a_backlog_stop: assert property (gearing_on_o && !fault_led_o
        && !avs_write_i && gear_backlog_i > `BACKLOG_MAX
        |=> !gearing_on_o && fault_led_o) else $error("backlog kept gearing");
    a_block_run: assert property (int_block_o |-> program_run_o)
        else $error("blocked while idle");
    // ****************************************
    // Event edges and triggers
    // ****************************************
    a_rise_edge: assert property ($rose(event_i) |-> ##[2:3] event_rise_o)
        else $error("rise pulse missing");
    a_fall_edge: assert property ($fell(event_i) |-> ##[2:3] event_fall_o)
        else $error("fall pulse missing");
    a_rise_single: assert property (event_rise_o |=> !event_rise_o)
        else $error("rise pulse too long");
    a_trig_cause: assert property (home_trigger_o || index_start_o
        |-> $past(event_rise_o) || $past(event_fall_o) || $past(enc_index_i))
        else $error("trigger without event edge");
    c_home: cover property (home_trigger_o);
    c_index: cover property (index_start_o);
    c_fault: cover property ($rose(fault_led_o));
endmodule

bind servo_fault_trigger_unit servo_unit_chk u_chk (
    .mclk_i(mclk_i), .reset_i(reset_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_address_i(avs_address_i),
    .avs_waitrequest_o(avs_waitrequest_o), .pos_limit_i(pos_limit_i),
    .neg_limit_i(neg_limit_i), .event_i(event_i), .move_req_i(move_req_i),
    .enc_index_i(enc_index_i),
    .gear_backlog_i(gear_backlog_i), .cmd_fault_i(cmd_fault_i),
    .fault_led_o(fault_led_o), .drive_enable_o(drive_enable_o),
    .gearing_on_o(gearing_on_o), .program_run_o(program_run_o),
    .int_block_o(int_block_o), .home_trigger_o(home_trigger_o),
    .index_start_o(index_start_o), .event_rise_o(event_rise_o),
    .event_fall_o(event_fall_o)
);

// ### sim/tb_top.sv
// Self-checking testbench for the servo fault and trigger unit
`timescale 1ns/1ps
`include "servo_fault_consts.svh"
module tb_top;
    logic clk = 0, rst = 1, rd = 0, wr = 0, mv = 0, md = 0;
    logic spin = 0, dir = 0, ev = 0, pl = 0, nl = 0;
    logic [5:0] adr = 6'h00;
    logic [7:0] cf = 8'h00;
    logic [31:0] wd = 32'h0, blg = 32'h0, rdq;
    wire ea, eb, ei, plo, nlo, evo, wt, led, drv, gon, run, blk, ht, ix;
    int steps, err_total = 0, n_tests = 0, hc = 0, ic = 0;
    always #50 clk = ~clk;
    always @(negedge clk) begin
        hc += ht;
        ic += ix;
    end
    sensor_model sm (.mclk_i(clk), .spin_i(spin), .dir_i(dir), .ev_i(ev),
        .plim_i(pl), .nlim_i(nl), .enc_a_o(ea), .enc_b_o(eb),
        .enc_index_o(ei), .pos_limit_o(plo), .neg_limit_o(nlo),
        .event_o(evo), .steps_o(steps));
    servo_fault_trigger_unit #(.SAMPLE_CYCLES(20)) dut (.mclk_i(clk),
        .reset_i(rst), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdq),
        .avs_waitrequest_o(wt), .enc_a_i(ea), .enc_b_i(eb),
        .enc_index_i(ei), .pos_limit_i(plo), .neg_limit_i(nlo),
        .event_i(evo), .gear_backlog_i(blg), .cmd_fault_i(cf),
        .move_req_i(mv), .move_done_i(md), .fault_led_o(led),
        .drive_enable_o(drv), .gearing_on_o(gon), .program_run_o(run),
        .int_block_o(blk), .home_trigger_o(ht), .index_start_o(ix),
        .event_rise_o(), .event_fall_o());
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_sim;
        $display("mismatches %0d of %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Request held until the edge where waitrequest is seen low
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 40);
        q = rdq;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 40) begin
            err_total++;
            end_sim;
        end
    endtask
    task automatic bw(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic ev_set(input logic v);
        @(posedge clk);
        ev <= v;
        cyc(10);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_pos;
        rc(`OFS_POSITION, 32'h0);
        bw(`OFS_COMMANDED, 32'hffff_ff00);
        rc(`OFS_POSITION, 32'hffff_ff00);
        rc(`OFS_COMMANDED, 32'hffff_ff00);
        rc(6'h3c, 32'h0);
    endtask
    task automatic t_speed;
        logic [31:0] s, p;
        bw(`OFS_COMMANDED, 32'h100);
        @(posedge clk);
        spin <= 1'b1;
        dir <= 1'b1;
        cyc(80);
        bus(1'b0, `OFS_SPEED, 32'h0, s);
        chk(s[31] ? -s : s, 32'ha);
        @(posedge clk);
        spin <= 1'b0;
        cyc(40);
        bus(1'b0, `OFS_POSITION, 32'h0, p);
        chk(p, s[31] ? 32'h100 - steps : 32'h100 + steps);
        @(posedge clk);
        spin <= 1'b1;
        dir <= 1'b0;
        cyc(80);
        bus(1'b0, `OFS_SPEED, 32'h0, p);
        chk(p, -s);
        @(posedge clk);
        spin <= 1'b0;
        cyc(40);
    endtask
    task automatic t_fault;
        logic [7:0] codes[3] = '{8'h06, 8'h07, 8'h0a};
        foreach (codes[i]) begin
            @(posedge clk);
            cf <= codes[i];
            @(posedge clk);
            cf <= 8'h01;
            @(posedge clk);
            cf <= 8'h00;
            @(negedge clk) chk(led, 1'b1);
            rc(`OFS_FAULT, codes[i]);
            @(negedge clk) chk(led, 1'b0);
        end
        @(posedge clk);
        mv <= 1'b1;
        @(posedge clk);
        mv <= 1'b0;
        rc(`OFS_FAULT, `FLT_NO_DRIVE);
    endtask
    task automatic t_gear;
        logic [31:0] ctl[5] = '{32'ha, 32'ha, 32'hc, 32'hc, 32'h8};
        logic [31:0] cp[5] = '{32'h0, 32'h0, 32'hb, 32'hffff_fff5, 32'h0};
        logic [7:0] code[5] = '{`FLT_HARD_POS, `FLT_HARD_NEG,
            `FLT_SOFT_POS, `FLT_SOFT_NEG, `FLT_BACKLOG};
        bw(`OFS_SOFT_POS, 32'ha);
        bw(`OFS_SOFT_NEG, 32'hffff_fff6);
        for (int i = 0; i < 5; i++) begin
            blg <= `BACKLOG_MAX;
            bw(`OFS_COMMANDED, cp[i]);
            bw(`OFS_CTRL, ctl[i]);
            if (i != 2 && i != 3)
                @(negedge clk) chk({gon, led}, 2'b10);
            @(posedge clk);
            pl <= (i == 0);
            nl <= (i == 1);
            blg <= (i == 4) ? 32'h8000 : 32'h0;
            cyc(3);
            @(negedge clk) chk({gon, led}, 2'b01);
            rc(`OFS_FAULT, code[i]);
            @(posedge clk);
            pl <= 1'b0;
            nl <= 1'b0;
            blg <= 32'h0;
        end
        bw(`OFS_CTRL, 32'h0);
    endtask
    task automatic t_handler;
        bw(`OFS_CTRL, 32'h50);
        @(posedge clk);
        cf <= 8'h0a;
        @(posedge clk);
        cf <= 8'h00;
        @(negedge clk) chk({run, blk, led}, 3'b111);
        bw(`OFS_FAULT_EXIT, 32'h0);
        @(negedge clk) chk({run, blk, led}, 3'b100);
        bw(`OFS_CTRL, 32'h0);
        bw(`OFS_CTRL, 32'h40);
        @(posedge clk);
        cf <= 8'h0a;
        @(posedge clk);
        cf <= 8'h00;
        @(negedge clk) chk({run, blk}, 2'b00);
        rc(`OFS_FAULT, 32'ha);
    endtask
    task automatic t_follow;
        bw(`OFS_FOLLOW, 32'h0);
        bw(`OFS_CTRL, 32'h1);
        @(posedge clk);
        spin <= 1'b1;
        cyc(20);
        @(negedge clk) chk({drv, led}, 2'b10);
        bw(`OFS_FOLLOW, 32'h4);
        cyc(20);
        @(negedge clk) chk({drv, led}, 2'b01);
        rc(`OFS_FAULT, `FLT_FOLLOW);
        @(posedge clk);
        spin <= 1'b0;
        bw(`OFS_FOLLOW, 32'h0);
    endtask
    task automatic t_trig;
        logic [31:0] q;
        bw(`OFS_CTRL, 32'h1);
        bw(`OFS_TRIGGER, 32'hffff_ffff);
        bw(`OFS_CYCLE, 32'h1);
        ev_set(1'b1);
        chk(hc, 32'h0);
        ev_set(1'b0);
        chk(hc, 32'h1);
        bw(`OFS_TRIGGER, 32'h0);
        bw(`OFS_CYCLE, 32'h1);
        ev_set(1'b1);
        bus(1'b0, `OFS_STATUS, 32'h0, q);
        chk(q[5], 1'b1);
        ev_set(1'b0);
        chk(hc, 32'h2);
        bw(`OFS_CTRL, 32'h21);
        bw(`OFS_CYCLE, 32'h1);
        @(posedge clk);
        spin <= 1'b1;
        ev_set(1'b1);
        ev_set(1'b0);
        cyc(10);
        chk(hc, 32'h3);
        @(posedge clk);
        spin <= 1'b0;
        bw(`OFS_CTRL, 32'h1);
        bw(`OFS_TRIGGER, 32'h1);
        bw(`OFS_CYCLE, 32'h2);
        bw(`OFS_TRIGGER, 32'h0);
        ev_set(1'b1);
        chk(ic, 32'h1);
        ev_set(1'b0);
        @(posedge clk);
        md <= 1'b1;
        @(posedge clk);
        md <= 1'b0;
        bw(`OFS_TRIGGER, 32'h0);
        bw(`OFS_CYCLE, 32'h2);
        ev_set(1'b1);
        ev_set(1'b0);
        chk(ic, 32'h1);
    endtask
    initial begin
        cyc(2);
        rst <= 1'b0;
        t_pos();
        t_speed();
        t_fault();
        t_gear();
        t_handler();
        t_follow();
        t_trig();
        end_sim();
    end
endmodule
